// [hdl/dp12_datapath.sv]
// twelve-bit processor datapath: buses, adder, shifter, skip and overflow
`timescale 1ns/1ps
module dp12_datapath
  import dp12_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST,
  input  wire logic [2:0]        INPUT_SELECT,
  input  wire logic              BREAK_DATA_GATE_N,
  input  wire logic              DATA_TO_ADDERS,
  input  wire logic              DATA_COMPLEMENT,
  input  wire logic              AND_MODE,
  input  wire logic              INCREMENT_REQ,
  input  wire logic              SKIP_SET_GROUP2,
  input  wire logic              SKIP_CLEAR,
  input  wire logic              INCREMENT_SKIP_IF_ZERO_OP,
  input  wire logic              SECOND_TIME_PULSE,
  input  wire logic              RIGHT_N,
  input  wire logic              LEFT_N,
  input  wire logic              TWICE_N,
  input  wire logic              PAGE_ZERO_N,
  input  wire logic [2:0]        LOAD_DEST,
  input  wire logic [1:0]        DATA_BUS_DRIVE,
  input  wire logic              MEMORY_DATA_DIRECTION,
  input  wire logic              OPTION_ADDRESS_DISABLE_N,
  input  wire logic [11:0]       OPTION_ADDRESS,
  input  wire logic [11:0]       MEM_SENSE,
  input  wire logic [11:0]       MD_BUS_IN,
  input  wire logic              MD_OPTION_DRIVE,
  input  wire logic [11:0]       DATA_BUS_IN_N,
  input  wire logic [11:0]       SWITCH_REG,
  input  wire logic              DEPOSIT_KEY,
  input  wire logic              FIELD_ADDRESS_LOAD_KEY,
  input  wire logic              TRANSFER_EXTEND_REQUEST_N,
  output logic [11:0]            MD_BUS_OUT,
  output logic                   MD_BUS_OE,
  output logic [11:0]            MA_BUS,
  output logic [11:0]            DATA_BUS_OUT_N,
  output logic                   DATA_BUS_OE,
  output logic [2:0]             FIELD,
  output logic                   ADDER_CARRY_OUT_N,
  output logic                   ADDER_CARRY_IN_N,
  output logic                   OVERFLOW_N,
  output logic                   SKIP_N,
  output logic                   TRANSFER_EXTENDED,
  output logic                   MEMORY_WRITE,
  output logic [11:0]            WORKING_REGISTER,
  output logic [11:0]            PROGRAM_COUNTER
);
  typedef struct packed {
    logic [11:0] ac;
    logic [11:0] mq;
    logic [11:0] pc;
    logic [11:0] central_memory_address_register;
    logic [11:0] mb;
    logic [2:0]  field;
    logic        skip;
    logic        ovf;
    logic        ext_s1;
    logic        ext_s2;
    logic        mem_wr;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [11:0] reg_in;
  logic [11:0] data_in;
  logic [11:0] md_bus;
  logic [11:0] bus_b;
  logic [12:0] sum;
  logic [11:0] shifted;
  logic [11:0] major_bus;
  logic        cin;
  logic [1:0]  cin_val;

  ////////////////////////////////////////////////////////////////////////////
  // input mux and adder

  function automatic logic [11:0] pick_reg(input logic [2:0] sel, input state_t s, input logic [11:0] md);
    logic [11:0] v;
    v = WORD_ZERO;
    unique case (sel)
      SEL_AC:   v = s.ac;
      SEL_MQ:   v = s.mq;
      SEL_PC:   v = s.pc;
      SEL_CENTRAL_MEMORY_ADDRESS_REGISTER: v = s.central_memory_address_register;
      SEL_MD:   v = md;
      default:  v = WORD_ZERO;
    endcase
    return v;
  endfunction

  // memory data bus, one source at a time
  always_comb begin
    if (MD_OPTION_DRIVE) begin
      md_bus = MD_BUS_IN;
    end else if (MEMORY_DATA_DIRECTION) begin
      md_bus = st_r.mb;
    end else begin
      md_bus = MEM_SENSE;
    end
  end

  always_comb begin
    if (!BREAK_DATA_GATE_N) begin
      reg_in = md_bus;
    end else begin
      reg_in = pick_reg(INPUT_SELECT, st_r, md_bus);
    end
  end

  assign data_in = ~DATA_BUS_IN_N;
  assign bus_b   = DATA_TO_ADDERS ? (DATA_COMPLEMENT ? ~data_in : data_in) : WORD_ZERO;
  assign cin     = INCREMENT_REQ | st_r.skip;
  // a set skip flag adds one on top of a requested increment
  assign cin_val = {1'b0, INCREMENT_REQ} + {1'b0, st_r.skip};
  // bit 0 is the msb, held at vector index 11
  assign sum = AND_MODE ? {1'b0, reg_in & bus_b}
                        : ({1'b0, reg_in} + {1'b0, bus_b} + {11'h000, cin_val});

  ////////////////////////////////////////////////////////////////////////////
  // output shifter and page zero

  always_comb begin
    shifted = sum[11:0];
    unique case ({RIGHT_N, LEFT_N, TWICE_N})
      3'b011:  shifted = {sum[0], sum[11:1]};
      3'b101:  shifted = {sum[10:0], sum[11]};
      3'b010:  shifted = {sum[1:0], sum[11:2]};
      3'b100:  shifted = {sum[9:0], sum[11:10]};
      3'b110:  shifted = {sum[5:0], sum[11:6]};
      default: shifted = sum[11:0];
    endcase
    major_bus = shifted;
    if (!PAGE_ZERO_N) begin
      major_bus[11:7] = 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state update

  always_comb begin
    st_nxt        = st_r;
    st_nxt.ext_s1 = ~TRANSFER_EXTEND_REQUEST_N;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.mem_wr = 1'b0;
    st_nxt.ovf    = SECOND_TIME_PULSE & sum[12];
    unique case (LOAD_DEST)
      DST_AC:   st_nxt.ac   = major_bus;
      DST_MQ:   st_nxt.mq   = major_bus;
      DST_PC:   st_nxt.pc   = major_bus;
      DST_CENTRAL_MEMORY_ADDRESS_REGISTER: st_nxt.central_memory_address_register = major_bus;
      DST_MB:   st_nxt.mb   = major_bus;
      default:  st_nxt.ac   = st_r.ac;
    endcase
    if (SKIP_CLEAR) begin
      st_nxt.skip = 1'b0;
    end
    if ((SECOND_TIME_PULSE & sum[12] & INCREMENT_SKIP_IF_ZERO_OP) | SKIP_SET_GROUP2) begin
      st_nxt.skip = 1'b1;
    end
    if (DEPOSIT_KEY) begin
      st_nxt.mb     = SWITCH_REG;
      st_nxt.mem_wr = 1'b1;
    end
    if (FIELD_ADDRESS_LOAD_KEY) begin
      st_nxt.field = SWITCH_REG[2:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    DATA_BUS_OE    = 1'b1;
    DATA_BUS_OUT_N = WORD_ONES;
    unique case (DATA_BUS_DRIVE)
      DBUS_AC: DATA_BUS_OUT_N = ~st_r.ac;
      DBUS_MQ: DATA_BUS_OUT_N = ~st_r.mq;
      default: DATA_BUS_OE    = 1'b0;
    endcase
  end

  assign MD_BUS_OUT        = st_r.mb;
  assign MD_BUS_OE         = MEMORY_DATA_DIRECTION & ~MD_OPTION_DRIVE;
  assign MA_BUS            = OPTION_ADDRESS_DISABLE_N ? st_r.central_memory_address_register : OPTION_ADDRESS;
  assign FIELD             = st_r.field;
  assign ADDER_CARRY_OUT_N = ~sum[12];
  assign ADDER_CARRY_IN_N  = ~cin;
  assign OVERFLOW_N        = ~st_r.ovf;
  assign SKIP_N            = ~st_r.skip;
  assign TRANSFER_EXTENDED = st_r.ext_s2;
  assign MEMORY_WRITE      = st_r.mem_wr;
  assign WORKING_REGISTER  = st_r.ac;
  assign PROGRAM_COUNTER   = st_r.pc;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_overflow_pulse: assert property (@(posedge CLOCK) disable iff (RST)
    (SECOND_TIME_PULSE && sum[12]) |=> !OVERFLOW_N)
    else $error("overflow not raised");
  chk_carry_ones: assert property (@(posedge CLOCK) disable iff (RST)
    (!AND_MODE && reg_in == WORD_ONES && bus_b == WORD_ZERO && cin) |-> !ADDER_CARRY_OUT_N)
    else $error("carry out missing");
  chk_skip_isz: assert property (@(posedge CLOCK) disable iff (RST)
    (SECOND_TIME_PULSE && sum[12] && INCREMENT_SKIP_IF_ZERO_OP) |=> !SKIP_N)
    else $error("skip not set");
  chk_skip_carry: assert property (@(posedge CLOCK) disable iff (RST)
    !SKIP_N |-> !ADDER_CARRY_IN_N)
    else $error("skip did not drive carry in");
  chk_swap_halves: assert property (@(posedge CLOCK) disable iff (RST)
    (RIGHT_N && LEFT_N && !TWICE_N) |-> shifted == {sum[5:0], sum[11:6]})
    else $error("swap wrong");
  chk_page_zero: assert property (@(posedge CLOCK) disable iff (RST)
    !PAGE_ZERO_N |-> major_bus[11:7] == 5'h00)
    else $error("page zero not forced");
  chk_break_gate: assert property (@(posedge CLOCK) disable iff (RST)
    !BREAK_DATA_GATE_N |-> reg_in == md_bus)
    else $error("break data not gated");
  chk_deposit_write: assert property (@(posedge CLOCK) disable iff (RST)
    DEPOSIT_KEY |=> (MEMORY_WRITE && MD_BUS_OUT == $past(SWITCH_REG)))
    else $error("deposit not written");
  chk_field_load: assert property (@(posedge CLOCK) disable iff (RST)
    FIELD_ADDRESS_LOAD_KEY |=> FIELD == $past(SWITCH_REG[2:0]))
    else $error("field not loaded");
  chk_md_direction: assert property (@(posedge CLOCK) disable iff (RST)
    (!MD_OPTION_DRIVE && !MEMORY_DATA_DIRECTION) |-> md_bus == MEM_SENSE)
    else $error("sense register not on bus");
  chk_skip_wins: assert property (@(posedge CLOCK) disable iff (RST)
    (SKIP_SET_GROUP2 && SKIP_CLEAR) |=> !SKIP_N)
    else $error("skip set lost to clear");
  chk_skip_clear: assert property (@(posedge CLOCK) disable iff (RST)
    (SKIP_CLEAR && !SKIP_SET_GROUP2 && !(SECOND_TIME_PULSE && sum[12] && INCREMENT_SKIP_IF_ZERO_OP)) |=> SKIP_N)
    else $error("skip not cleared");
  chk_overflow_clear: assert property (@(posedge CLOCK) disable iff (RST)
    !(SECOND_TIME_PULSE && sum[12]) |=> OVERFLOW_N)
    else $error("overflow held too long");
  chk_carry_in_pin: assert property (@(posedge CLOCK) disable iff (RST)
    INCREMENT_REQ |-> !ADDER_CARRY_IN_N)
    else $error("carry in missing");
  chk_skip_extra: assert property (@(posedge CLOCK) disable iff (RST)
    (!AND_MODE && INCREMENT_REQ && !SKIP_N) |-> sum == {1'b0, reg_in} + {1'b0, bus_b} + 13'h0002)
    else $error("skip gave no extra increment");
  chk_extend_sync: assert property (@(posedge CLOCK) disable iff (RST)
    (!$past(RST) && !$past(RST, 2)) |-> TRANSFER_EXTENDED != $past(TRANSFER_EXTEND_REQUEST_N, 2))
    else $error("extend request not synchronised");
  chk_deposit_pulse: assert property (@(posedge CLOCK) disable iff (RST)
    !DEPOSIT_KEY |=> !MEMORY_WRITE)
    else $error("memory write without deposit");
  chk_md_option: assert property (@(posedge CLOCK) disable iff (RST)
    MD_OPTION_DRIVE |-> (!MD_BUS_OE && md_bus == MD_BUS_IN))
    else $error("option data not on memory bus");
  chk_ma_option: assert property (@(posedge CLOCK) disable iff (RST)
    !OPTION_ADDRESS_DISABLE_N |-> MA_BUS == OPTION_ADDRESS)
    else $error("option address not on address bus");
  chk_data_bus_ac: assert property (@(posedge CLOCK) disable iff (RST)
    (DATA_BUS_DRIVE == DBUS_AC) |-> (DATA_BUS_OE && DATA_BUS_OUT_N == ~WORKING_REGISTER))
    else $error("working register not on data bus");
  chk_data_bus_idle: assert property (@(posedge CLOCK) disable iff (RST)
    (DATA_BUS_DRIVE == DBUS_NONE) |-> (!DATA_BUS_OE && DATA_BUS_OUT_N == WORD_ONES))
    else $error("data bus driven while idle");
  chk_pc_load: assert property (@(posedge CLOCK) disable iff (RST)
    (LOAD_DEST == DST_PC) |=> PROGRAM_COUNTER == $past(major_bus))
    else $error("program counter not loaded");
  chk_and_mode: assert property (@(posedge CLOCK) disable iff (RST)
    AND_MODE |-> sum == {1'b0, reg_in & bus_b})
    else $error("and result wrong");
  chk_shift_none: assert property (@(posedge CLOCK) disable iff (RST)
    (RIGHT_N && LEFT_N && TWICE_N) |-> shifted == sum[11:0])
    else $error("unshifted path wrong");
  chk_right_once: assert property (@(posedge CLOCK) disable iff (RST)
    (!RIGHT_N && LEFT_N && TWICE_N) |-> shifted == {sum[0], sum[11:1]})
    else $error("right shift wrong");
endmodule

// [pkg/dp12_pkg.sv]
// constants for the twelve-bit processor datapath
package dp12_pkg;
  localparam int WORD_W  = 12;
  localparam int FIELD_W = 3;
  localparam int HALF_W  = 6;
  localparam int PAGE_W  = 5;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [11:0] WORD_ONES = 12'hFFF;
  localparam logic [2:0]  FIELD_RST = 3'h0;
  // input select codes {input_select_2, input_select_1, input_select_0}
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_AC   = 3'h1;
  localparam logic [2:0] SEL_MQ   = 3'h2;
  localparam logic [2:0] SEL_PC   = 3'h3;
  localparam logic [2:0] SEL_CENTRAL_MEMORY_ADDRESS_REGISTER = 3'h4;
  localparam logic [2:0] SEL_MD   = 3'h5;
  // destination codes on the major-registers bus
  localparam logic [2:0] DST_NONE = 3'h0;
  localparam logic [2:0] DST_AC   = 3'h1;
  localparam logic [2:0] DST_MQ   = 3'h2;
  localparam logic [2:0] DST_PC   = 3'h3;
  localparam logic [2:0] DST_CENTRAL_MEMORY_ADDRESS_REGISTER = 3'h4;
  localparam logic [2:0] DST_MB   = 3'h5;
  // data bus drive codes
  localparam logic [1:0] DBUS_NONE = 2'h0;
  localparam logic [1:0] DBUS_AC   = 2'h1;
  localparam logic [1:0] DBUS_MQ   = 2'h2;
  // memory cycle 1.2 us at 5 ns
  localparam int XFER_NS     = 1200;
  localparam int CLK_NS      = 5;
  localparam int XFER_CYCLES = XFER_NS / CLK_NS;
endpackage

// [test/dp12_mem_model.sv]
// core memory, memory option and slow peripheral model for the datapath bench
`timescale 1ns/1ps
module dp12_mem_model (
  input  wire logic        clock,
  input  wire logic [11:0] ma_bus,
  input  wire logic [11:0] md_bus_out,
  input  wire logic        memory_write,
  input  wire logic        option_drive,
  input  wire logic        slow_device,
  output logic [11:0]      mem_sense,
  output logic [11:0]      md_bus_in,
  output logic             extend_n
);
  logic [11:0] core_r [0:4095];
  logic [11:0] idle_r = 12'hA5A;
  initial begin
    for (int i = 0; i < 4096; i++) begin
      core_r[i] = 12'(i);
    end
  end
  always @(posedge clock) begin
    idle_r <= ~idle_r;
    if (memory_write) begin
      core_r[ma_bus] <= md_bus_out;
    end
  end
  assign mem_sense = core_r[ma_bus];
  assign md_bus_in = option_drive ? 12'h3C3 : idle_r;
  assign extend_n  = ~slow_device;
endmodule

// [test/dp12_datapath_tb.sv]
// self-checking bench for the twelve-bit datapath
`timescale 1ns/1ps
module dp12_datapath_tb
  import dp12_pkg::*;
;
  logic CLOCK, RST, BREAK_DATA_GATE_N, DATA_TO_ADDERS, DATA_COMPLEMENT, AND_MODE, INCREMENT_REQ, slow;
  logic SKIP_SET_GROUP2, SKIP_CLEAR, INCREMENT_SKIP_IF_ZERO_OP, SECOND_TIME_PULSE, RIGHT_N, LEFT_N, TWICE_N;
  logic PAGE_ZERO_N, MEMORY_DATA_DIRECTION, OPTION_ADDRESS_DISABLE_N, MD_OPTION_DRIVE, DEPOSIT_KEY;
  logic FIELD_ADDRESS_LOAD_KEY, TRANSFER_EXTEND_REQUEST_N, MD_BUS_OE, DATA_BUS_OE, ADDER_CARRY_OUT_N;
  logic ADDER_CARRY_IN_N, OVERFLOW_N, SKIP_N, TRANSFER_EXTENDED, MEMORY_WRITE;
  logic [2:0]  INPUT_SELECT, LOAD_DEST, FIELD;
  logic [1:0]  DATA_BUS_DRIVE;
  logic [11:0] OPTION_ADDRESS, MEM_SENSE, MD_BUS_IN, DATA_BUS_IN_N, SWITCH_REG, MD_BUS_OUT, MA_BUS;
  logic [11:0] DATA_BUS_OUT_N, WORKING_REGISTER, PROGRAM_COUNTER;
  logic [14:0] shtab [6] = '{15'h3078, 15'h51E0, 15'h203C, 15'h43C0, 15'h6C03, 15'h70F0};
  int          n_mismatch = 0;
  int          n_compared = 0;

  dp12_datapath u_dut (
    .CLOCK(CLOCK), .RST(RST), .INPUT_SELECT(INPUT_SELECT), .BREAK_DATA_GATE_N(BREAK_DATA_GATE_N),
    .DATA_TO_ADDERS(DATA_TO_ADDERS), .DATA_COMPLEMENT(DATA_COMPLEMENT), .AND_MODE(AND_MODE),
    .INCREMENT_REQ(INCREMENT_REQ), .SKIP_SET_GROUP2(SKIP_SET_GROUP2), .SKIP_CLEAR(SKIP_CLEAR),
    .INCREMENT_SKIP_IF_ZERO_OP(INCREMENT_SKIP_IF_ZERO_OP), .SECOND_TIME_PULSE(SECOND_TIME_PULSE),
    .RIGHT_N(RIGHT_N), .LEFT_N(LEFT_N), .TWICE_N(TWICE_N), .PAGE_ZERO_N(PAGE_ZERO_N), .LOAD_DEST(LOAD_DEST),
    .DATA_BUS_DRIVE(DATA_BUS_DRIVE), .MEMORY_DATA_DIRECTION(MEMORY_DATA_DIRECTION),
    .OPTION_ADDRESS_DISABLE_N(OPTION_ADDRESS_DISABLE_N), .OPTION_ADDRESS(OPTION_ADDRESS),
    .MEM_SENSE(MEM_SENSE), .MD_BUS_IN(MD_BUS_IN), .MD_OPTION_DRIVE(MD_OPTION_DRIVE),
    .DATA_BUS_IN_N(DATA_BUS_IN_N), .SWITCH_REG(SWITCH_REG), .DEPOSIT_KEY(DEPOSIT_KEY),
    .FIELD_ADDRESS_LOAD_KEY(FIELD_ADDRESS_LOAD_KEY), .TRANSFER_EXTEND_REQUEST_N(TRANSFER_EXTEND_REQUEST_N),
    .MD_BUS_OUT(MD_BUS_OUT), .MD_BUS_OE(MD_BUS_OE), .MA_BUS(MA_BUS), .DATA_BUS_OUT_N(DATA_BUS_OUT_N),
    .DATA_BUS_OE(DATA_BUS_OE), .FIELD(FIELD), .ADDER_CARRY_OUT_N(ADDER_CARRY_OUT_N),
    .ADDER_CARRY_IN_N(ADDER_CARRY_IN_N), .OVERFLOW_N(OVERFLOW_N), .SKIP_N(SKIP_N),
    .TRANSFER_EXTENDED(TRANSFER_EXTENDED), .MEMORY_WRITE(MEMORY_WRITE), .WORKING_REGISTER(WORKING_REGISTER),
    .PROGRAM_COUNTER(PROGRAM_COUNTER));
  dp12_mem_model u_mem (.clock(CLOCK), .ma_bus(MA_BUS), .md_bus_out(MD_BUS_OUT), .memory_write(MEMORY_WRITE),
    .option_drive(MD_OPTION_DRIVE), .slow_device(slow), .mem_sense(MEM_SENSE), .md_bus_in(MD_BUS_IN),
    .extend_n(TRANSFER_EXTEND_REQUEST_N));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic idle();
    INPUT_SELECT = SEL_NONE;
    LOAD_DEST = DST_NONE;
    DATA_BUS_DRIVE = DBUS_NONE;
    DATA_TO_ADDERS = 1'b1;
    DATA_BUS_IN_N = 12'hFFF;
    {RIGHT_N, LEFT_N, TWICE_N, PAGE_ZERO_N, BREAK_DATA_GATE_N} = 5'h1F;
    {DATA_COMPLEMENT, AND_MODE, INCREMENT_REQ, SKIP_SET_GROUP2, SKIP_CLEAR} = 5'h00;
    {INCREMENT_SKIP_IF_ZERO_OP, SECOND_TIME_PULSE, DEPOSIT_KEY, FIELD_ADDRESS_LOAD_KEY} = 4'h0;
  endtask
  task automatic alu(input logic [2:0] sel, input logic [2:0] dst, input logic [11:0] dat, input logic inc);
    INPUT_SELECT = sel;
    LOAD_DEST = dst;
    DATA_BUS_IN_N = ~dat;
    INCREMENT_REQ = inc;
    tick(1);
    idle();
  endtask
  task automatic stop_test();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_mismatch++;
    stop_test();
  end
  initial begin
    RST = 1'b1;
    slow = 1'b0;
    {MEMORY_DATA_DIRECTION, MD_OPTION_DRIVE, OPTION_ADDRESS_DISABLE_N} = 3'h5;
    OPTION_ADDRESS = 12'h7E1;
    SWITCH_REG = 12'h000;
    idle();
    tick(12);
    RST = 1'b0;
    chk({10'h000, OVERFLOW_N, SKIP_N}, 12'h003);
    for (int d = 1; d < 5; d++) begin
      alu(SEL_NONE, 3'(d), 12'(d * 12'h111), 1'b0);
    end
    chk(MA_BUS, 12'h444);
    OPTION_ADDRESS_DISABLE_N = 1'b0;
    tick(1);
    chk(MA_BUS, 12'h7E1);
    OPTION_ADDRESS_DISABLE_N = 1'b1;
    DATA_BUS_DRIVE = DBUS_AC;
    tick(1);
    chk({DATA_BUS_OE, DATA_BUS_OUT_N}, 13'h1EEE);
    DATA_BUS_DRIVE = DBUS_MQ;
    tick(1);
    chk(DATA_BUS_OUT_N, 12'hDDD);
    alu(SEL_MQ, DST_PC, 12'h000, 1'b0);
    chk(PROGRAM_COUNTER, 12'h222);
    alu(SEL_CENTRAL_MEMORY_ADDRESS_REGISTER, DST_AC, 12'h000, 1'b0);
    chk(WORKING_REGISTER, 12'h444);
    alu(SEL_NONE, DST_PC, 12'hFFF, 1'b0);
    {INPUT_SELECT, LOAD_DEST, INCREMENT_REQ} = {SEL_PC, DST_PC, 1'b1};
    {INCREMENT_SKIP_IF_ZERO_OP, SECOND_TIME_PULSE} = 2'h3;
    #1 chk({ADDER_CARRY_OUT_N, ADDER_CARRY_IN_N}, 12'h000);
    tick(1);
    idle();
    chk({OVERFLOW_N, PROGRAM_COUNTER}, 13'h0000);
    tick(1);
    chk({11'h000, SKIP_N}, 12'h000);
    alu(SEL_PC, DST_PC, 12'h000, 1'b1);
    chk(PROGRAM_COUNTER, 12'h002);
    SKIP_CLEAR = 1'b1;
    tick(1);
    alu(SEL_PC, DST_PC, 12'h000, 1'b1);
    chk({SKIP_N, PROGRAM_COUNTER}, 13'h1003);
    SKIP_SET_GROUP2 = 1'b1;
    tick(1);
    idle();
    chk({11'h000, SKIP_N}, 12'h000);
    SKIP_CLEAR = 1'b1;
    tick(1);
    idle();
    foreach (shtab[i]) begin
      alu(SEL_NONE, DST_AC, 12'h0F0, 1'b0);
      {RIGHT_N, LEFT_N, TWICE_N} = shtab[i][14:12];
      alu(SEL_AC, DST_AC, 12'h000, 1'b0);
      chk(WORKING_REGISTER, shtab[i][11:0]);
    end
    PAGE_ZERO_N = 1'b0;
    alu(SEL_NONE, DST_AC, 12'hFFF, 1'b0);
    chk(WORKING_REGISTER, 12'h07F);
    AND_MODE = 1'b1;
    alu(SEL_AC, DST_AC, 12'h0F0, 1'b0);
    chk(WORKING_REGISTER, 12'h070);
    DATA_COMPLEMENT = 1'b1;
    alu(SEL_NONE, DST_AC, 12'h00F, 1'b0);
    chk(WORKING_REGISTER, 12'hFF0);
    {SWITCH_REG, DEPOSIT_KEY} = {12'h6B5, 1'b1};
    tick(1);
    idle();
    chk({12'h000, MEMORY_WRITE}, 13'h0001);
    tick(2);
    chk({MD_BUS_OE, MD_BUS_OUT}, 13'h16B5);
    MD_OPTION_DRIVE = 1'b1;
    tick(1);
    chk({12'h000, MD_BUS_OE}, 13'h0000);
    alu(SEL_MD, DST_PC, 12'h000, 1'b0);
    chk(PROGRAM_COUNTER, 12'h3C3);
    {MD_OPTION_DRIVE, MEMORY_DATA_DIRECTION, BREAK_DATA_GATE_N} = 3'h0;
    tick(1);
    chk({12'h000, MD_BUS_OE}, 13'h0000);
    alu(SEL_NONE, DST_AC, 12'h000, 1'b0);
    chk(WORKING_REGISTER, 12'h6B5);
    alu(SEL_MD, DST_PC, 12'h000, 1'b0);
    chk(PROGRAM_COUNTER, 12'h6B5);
    DATA_BUS_DRIVE = DBUS_AC;
    tick(1);
    chk(DATA_BUS_OUT_N, 12'h94A);
    for (int f = 0; f < 8; f++) begin
      {SWITCH_REG, FIELD_ADDRESS_LOAD_KEY} = {12'(7 - f), 1'b1};
      tick(1);
      idle();
      chk({9'h000, FIELD}, 12'(7 - f));
    end
    slow = 1'b1;
    for (int w = 0; w < 8 && TRANSFER_EXTENDED !== 1'b1; w++) begin
      tick(1);
    end
    chk({11'h000, TRANSFER_EXTENDED}, 12'h001);
    slow = 1'b0;
    tick(4);
    chk({11'h000, TRANSFER_EXTENDED}, 12'h000);
    {SKIP_SET_GROUP2, SKIP_CLEAR} = 2'h3;
    tick(1);
    idle();
    chk({12'h000, SKIP_N}, 13'h0000);
    DATA_TO_ADDERS = 1'b0;
    alu(SEL_PC, DST_PC, 12'hFFF, 1'b0);
    chk({SKIP_N, PROGRAM_COUNTER}, 13'h06B6);
    RST = 1'b1;
    tick(1);
    RST = 1'b0;
    chk({SKIP_N, PROGRAM_COUNTER}, 13'h1000);
    chk(WORKING_REGISTER, 12'h000);
    stop_test();
  end
endmodule
